// ==== rtl/ebcps_pkg.sv ====
// Package: constants and types for the bus cycle phase sequencer
package ebcps_pkg;
   // Chip select count, timing field widths and bus widths
   localparam int CS_COUNT = 4;
   localparam int CS_IDX_W = 2;
   localparam int SETUP_W = 1;
   localparam int EXTEND_W = 2;
   localparam int CMD_W = 2;
   localparam int WSETUP_W = 1;
   localparam int ACCESS_W = 5;
   localparam int HOLD_W = 2;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [7:0] WINDOW_RESET = 8'hff;
   localparam logic [5:0] COUNT_RESET = 6'h00;
   // Clock figures
   localparam int SYS_CLK_MHZ = 50;
   localparam int SYS_CLK_PERIOD_NS = 1000 / SYS_CLK_MHZ;

   typedef struct packed {
      logic [SETUP_W-1:0] setup;     // Address setup minus one
      logic [EXTEND_W-1:0] extend;   // Extra setup on window change
      logic [CMD_W-1:0] cmd_delay;   // Command delay periods
      logic [WSETUP_W-1:0] wsetup;   // Write setup / tristate periods
      logic [ACCESS_W-1:0] access;   // Access periods minus one
      logic [HOLD_W-1:0] hold;       // Hold periods
      logic ready_en;                // Ready handshake enable
      logic ready_pol;               // Ready active level
      logic ready_async;             // Ready passes the synchroniser
   } ebcps_timing_t;

   typedef enum logic [2:0] {
      EBCPS_IDLE = 3'b000,
      EBCPS_SETUP = 3'b001,
      EBCPS_CMD = 3'b010,
      EBCPS_WSETUP = 3'b011,
      EBCPS_ACCESS = 3'b100,
      EBCPS_HOLD = 3'b101
   } ebcps_phase_t;
endpackage

// ==== rtl/ebcps_req_if.sv ====
// Interface: request and timing carrier between sequencer parts
`timescale 1ns/1ns
interface ebcps_req_if;
   import ebcps_pkg::*;
   logic [CS_IDX_W-1:0] cs;
   ebcps_timing_t timing;
   modport sel (input cs, output timing);
   modport seq (output cs, input timing);
endinterface

// ==== rtl/ebcps_timing_sel.sv ====
// Chip select timing table: picks the settings for one chip select
`timescale 1ns/1ns
module ebcps_timing_sel
   import ebcps_pkg::*;
(
   input wire ebcps_timing_t chip_select_timing_control [CS_COUNT], // Table
   ebcps_req_if.sel req                                           // Carrier
);
   assign req.timing = chip_select_timing_control[req.cs];
endmodule

// ==== rtl/ebcps_seq.sv ====
// Top: external bus cycle phase sequencer
`timescale 1ns/1ns
// Function
// - Each cycle runs setup, command delay, write setup, access, hold.
// - Phase lengths come from per chip select timing settings.
// - Setup is one or two periods, plus zero to three on window change.
// - Write setup / tristate phase lasts zero or one period.
// - Hold phase lasts zero to three periods.
// - Access lasts 1 to 32 periods, stretched by ready when enabled.
// - Reference clock output is the system clock, fast driver enabled.
module ebcps_seq
   import ebcps_pkg::*;
(
   input wire logic sys_clk,                       // System clock
   input wire logic rst,                           // Async reset, high
   input wire ebcps_timing_t chip_select_timing_control [CS_COUNT], // Table
   input wire logic req_valid,                     // Cycle request
   output logic req_ready,                         // Request taken
   input wire logic [CS_IDX_W-1:0] req_cs,         // Chip select index
   input wire logic [ADDR_W-1:0] req_addr,         // Cycle address
   input wire logic req_write,                     // Write when high
   input wire logic [DATA_W-1:0] req_wdata,        // Write data
   input wire logic [7:0] req_window,              // Address window id
   output logic done,                              // Cycle finished pulse
   output logic [DATA_W-1:0] rdata,                // Read data
   input wire logic ready_pin,                     // Ready handshake pin
   input wire logic [DATA_W-1:0] data_in,          // Bus data input
   output logic [ADDR_W-1:0] bus_addr,             // Address output
   output logic [DATA_W-1:0] data_out,             // Bus data output
   output logic data_oe,                           // Data drive enable
   output logic cs_active,                         // Chip select strobe
   output logic rd_active,                         // Read command
   output logic wr_active,                         // Write command
   output ebcps_phase_t phase,                     // Current phase
   output logic external_clock_output_select,      // Clock source select
   output logic clk_fast_driver_en,                // Fast clock driver
   output logic bus_reference_clock_out            // Reference clock
);
   // =====================================================
   // Timing lookup
   ebcps_req_if req ();
   ebcps_timing_t cur;
   logic [CS_IDX_W-1:0] cs_q;
   logic write_q;
   logic [7:0] window_q;
   logic [5:0] count;
   logic [2:0] rdy_sync;
   logic rdy_pin_act;
   logic rdy_seen;
   logic access_end;
   logic [2:0] setup_len;
   logic req_window_changed;
   logic window_change_q;

   assign req.cs = cs_q;
   ebcps_timing_sel u_sel (
      .chip_select_timing_control(chip_select_timing_control),
      .req(req)
   );
   assign cur = req.timing;

   // =====================================================
   // Reference clock
   assign external_clock_output_select = 1'b1;
   assign clk_fast_driver_en = 1'b1;
   assign bus_reference_clock_out = sys_clk;

   // =====================================================
   // Ready handshake
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdy_sync <= 3'h0;
      end else begin
         rdy_sync <= {rdy_sync[1:0], ready_pin};
      end
   end

   // Async mode waits for the agreeing second and third stage
   always_comb begin
      if (cur.ready_async) begin
         rdy_pin_act = (rdy_sync[1] == rdy_sync[2]) &&
                       (rdy_sync[2] == cur.ready_pol);
      end else begin
         rdy_pin_act = (ready_pin == cur.ready_pol);
      end
   end

   assign rdy_seen = !cur.ready_en || rdy_pin_act;
   assign access_end = (count == {1'b0, cur.access}) && rdy_seen;
   assign req_ready = (phase == EBCPS_IDLE);

   // Setup length; window change adds extra periods
   always_comb begin
      setup_len = 3'(cur.setup) + 3'h1;
      if (req_window_changed) begin
         setup_len = setup_len + 3'(cur.extend);
      end
   end

   assign req_window_changed = window_change_q;

   // =====================================================
   // Phase sequencer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= EBCPS_IDLE;
         count <= COUNT_RESET;
      end else begin
         unique case (phase)
            EBCPS_IDLE: begin
               count <= COUNT_RESET;
               if (req_valid) begin
                  phase <= EBCPS_SETUP;
               end
            end
            EBCPS_SETUP: begin
               if (count == 6'(setup_len) - 6'h1) begin
                  count <= COUNT_RESET;
                  if (cur.cmd_delay != 2'h0) begin
                     phase <= EBCPS_CMD;
                  end else if (cur.wsetup != 1'b0) begin
                     phase <= EBCPS_WSETUP;
                  end else begin
                     phase <= EBCPS_ACCESS;
                  end
               end else begin
                  count <= count + 6'h1;
               end
            end
            EBCPS_CMD: begin
               if (count == 6'(cur.cmd_delay) - 6'h1) begin
                  count <= COUNT_RESET;
                  phase <= cur.wsetup ? EBCPS_WSETUP : EBCPS_ACCESS;
               end else begin
                  count <= count + 6'h1;
               end
            end
            EBCPS_WSETUP: begin
               count <= COUNT_RESET;
               phase <= EBCPS_ACCESS;
            end
            EBCPS_ACCESS: begin
               if (access_end) begin
                  count <= COUNT_RESET;
                  phase <= (cur.hold != 2'h0) ? EBCPS_HOLD : EBCPS_IDLE;
               end else if (count != {1'b0, cur.access}) begin
                  count <= count + 6'h1;
               end
            end
            EBCPS_HOLD: begin
               if (count == 6'(cur.hold) - 6'h1) begin
                  count <= COUNT_RESET;
                  phase <= EBCPS_IDLE;
               end else begin
                  count <= count + 6'h1;
               end
            end
            default: begin
               phase <= EBCPS_IDLE;
               count <= COUNT_RESET;
            end
         endcase
      end
   end

   // =====================================================
   // Request capture and window tracking
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_q <= '0;
         write_q <= 1'b0;
         bus_addr <= ADDR_RESET;
         data_out <= DATA_RESET;
         window_q <= WINDOW_RESET;
         window_change_q <= 1'b0;
      end else if (phase == EBCPS_IDLE && req_valid) begin
         cs_q <= req_cs;
         write_q <= req_write;
         bus_addr <= req_addr;
         data_out <= req_wdata;
         window_q <= req_window;
         window_change_q <= (req_window != window_q);
      end
   end

   // =====================================================
   // Bus strobes and read data
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_active <= 1'b0;
         rd_active <= 1'b0;
         wr_active <= 1'b0;
         data_oe <= 1'b0;
         done <= 1'b0;
         rdata <= DATA_RESET;
      end else begin
         done <= (phase == EBCPS_ACCESS) && access_end &&
                 (cur.hold == 2'h0);
         if (phase == EBCPS_HOLD && count == 6'(cur.hold) - 6'h1) begin
            done <= 1'b1;
         end
         cs_active <= (phase == EBCPS_IDLE) ? req_valid :
                      !(phase == EBCPS_HOLD &&
                        count == 6'(cur.hold) - 6'h1) &&
                      !(phase == EBCPS_ACCESS && access_end &&
                        cur.hold == 2'h0);
         // Command asserted through the access phase only
         rd_active <= !write_q && (phase == EBCPS_ACCESS ? !access_end :
                      (next_enters_access()));
         wr_active <= write_q && (phase == EBCPS_ACCESS ? !access_end :
                      (next_enters_access()));
         data_oe <= write_q && (phase != EBCPS_IDLE) &&
                    !(phase == EBCPS_HOLD &&
                      count == 6'(cur.hold) - 6'h1) &&
                    !(phase == EBCPS_ACCESS && access_end &&
                      cur.hold == 2'h0);
         if (phase == EBCPS_ACCESS && access_end && !write_q) begin
            rdata <= data_in;
         end
      end
   end

   function automatic logic next_enters_access();
      logic r;
      r = 1'b0;
      if (phase == EBCPS_WSETUP) begin
         r = 1'b1;
      end else if (phase == EBCPS_CMD) begin
         r = (count == 6'(cur.cmd_delay) - 6'h1) && !cur.wsetup;
      end else if (phase == EBCPS_SETUP) begin
         r = (count == 6'(setup_len) - 6'h1) && cur.cmd_delay == 2'h0 &&
             !cur.wsetup;
      end
      return r;
   endfunction
endmodule

// ==== tb/ebcps_ext_model.sv ====
// Partner: external bus module answering reads and driving ready
`timescale 1ns/1ns
module ebcps_ext_model
   import ebcps_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire ebcps_phase_t phase, // Sequencer phase
   input wire logic rd_active, // Read command
   input wire logic [ADDR_W-1:0] bus_addr, // Address
   input wire logic ready_pol, // Ready active level
   input wire logic [5:0] wait_n, // Access cycles before ready
   output logic ready_pin, // Ready to sequencer
   output logic [DATA_W-1:0] data_in // Read data
);
   logic [5:0] n = 6'h00;
   logic [DATA_W-1:0] last = 16'h0000;
   always @(posedge sys_clk) begin
      n <= (phase == EBCPS_ACCESS) ? n + 6'h01 : 6'h00;
      if (rd_active) begin
         last <= data_in;
      end
   end
   // Ready active only inside access, after the wait
   assign ready_pin = (phase == EBCPS_ACCESS && n >= wait_n) ? ready_pol
      : !ready_pol;
   // Released bus shows the inverse of the last word
   assign data_in = rd_active ? bus_addr[15:0] ^ 16'h5a5a : ~last;
endmodule

// ==== tb/ebcps_seq_assertions.sv ====
// Checker: phase order and phase lengths of the sequencer
`timescale 1ns/1ns
module ebcps_seq_assertions
   import ebcps_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire ebcps_timing_t chip_select_timing_control [CS_COUNT], // Table
   input wire logic req_valid, // Request
   input wire logic req_ready, // Taken
   input wire logic [CS_IDX_W-1:0] req_cs, // Chip select
   input wire ebcps_phase_t phase, // Phase
   input wire logic done, // Done pulse
   input wire logic external_clock_output_select, // Clock source
   input wire logic clk_fast_driver_en // Fast driver
);
   logic [CS_IDX_W-1:0] cs_q;
   ebcps_phase_t ph_q;
   logic [5:0] run;
   logic [5:0] idx;
   ebcps_timing_t t;
   // Index of the current cycle within its phase
   assign idx = (phase == ph_q) ? run : 6'h00;
   assign t = chip_select_timing_control[cs_q];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ph_q <= EBCPS_IDLE;
         run <= 6'h00;
      end else begin
         ph_q <= phase;
         run <= idx + 6'h01;
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_q <= '0;
      end else if (req_valid && req_ready) begin
         cs_q <= req_cs;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_left(ebcps_phase_t p);
      $past(phase) == p && phase != p;
   endsequence
   a_take_to_setup: assert property (s_take |=> phase == EBCPS_SETUP)
      else $error("take not followed by setup");
   a_phase_order: assert property ($changed(phase) |-> phase == EBCPS_IDLE
      || (phase > $past(phase) && ($past(phase) != EBCPS_IDLE
      || phase == EBCPS_SETUP))) else $error("phase order broken");
   a_setup_len: assert property (s_left(EBCPS_SETUP) |->
      $past(idx) >= 6'(t.setup) && $past(idx) <= 6'(t.setup) + 6'(t.extend))
      else $error("setup length wrong");
   a_cmd_len: assert property (s_left(EBCPS_CMD) |->
      $past(idx) + 6'h01 == 6'(t.cmd_delay)) else $error("cmd length wrong");
   a_wsetup_len: assert property (phase == EBCPS_WSETUP |->
      idx == 6'h00 && t.wsetup == 1'b1) else $error("wsetup length wrong");
   a_access_len: assert property (s_left(EBCPS_ACCESS) |-> (t.ready_en ?
      $past(idx) >= 6'(t.access) : $past(idx) == 6'(t.access)))
      else $error("access length wrong");
   a_hold_len: assert property (s_left(EBCPS_HOLD) |->
      $past(idx) + 6'h01 == 6'(t.hold)) else $error("hold length wrong");
   a_done_pulse: assert property (done |-> phase == EBCPS_IDLE ##1 !done)
      else $error("done pulse wrong");
   a_clk_source: assert property (external_clock_output_select
      && clk_fast_driver_en) else $error("reference clock not selected");
endmodule

// ==== tb/ext_bus_cycle_phase_sequencer_tb_top.sv ====
// Testbench: phase sequencer against an external module model
`timescale 1ns/1ns
module ext_bus_cycle_phase_sequencer_tb_top;
   import ebcps_pkg::*;
   typedef struct {int cs, win, wr, s, c, w, a, h;} ebcps_row_t;
   // cs0 minimum, cs1 maximum, cs2 ready direct, cs3 ready async low
   ebcps_timing_t tim [CS_COUNT] = '{16'h0000, 16'hfff8, 16'h486e, 16'h9415};
   ebcps_row_t rows [6] = '{'{0, 0, 1, 1, 0, 0, 1, 0},
      '{1, 0, 0, 2, 3, 1, 32, 3}, '{1, 1, 1, 5, 3, 1, 32, 3},
      '{2, 1, 0, 1, 1, 0, 4, 1}, '{2, 2, 1, 3, 1, 0, 4, 1},
      '{0, 2, 0, 1, 0, 0, 1, 0}};
   logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   logic pol = 1'b1, oe_seen;
   logic [CS_IDX_W-1:0] req_cs = '0;
   logic [ADDR_W-1:0] req_addr = '0, bus_addr;
   logic [DATA_W-1:0] req_wdata = '0, data_in, rdata, data_out;
   logic [7:0] req_window = '0;
   logic [5:0] wait_n = '0;
   logic req_ready, done, ready_pin, data_oe, cs_active, rd_active, ecs, cfe;
   logic rco, wr_active;
   ebcps_phase_t phase;
   int errors = 0, checks = 0;
   int cnt [6];
   ebcps_seq i_dut (.sys_clk, .rst, .chip_select_timing_control(tim),
      .req_valid, .req_ready, .req_cs, .req_addr, .req_write, .req_wdata,
      .req_window, .done, .rdata, .ready_pin, .data_in, .bus_addr, .data_out,
      .data_oe, .cs_active, .rd_active, .wr_active, .phase,
      .external_clock_output_select(ecs), .clk_fast_driver_en(cfe),
      .bus_reference_clock_out(rco));
   ebcps_ext_model i_mod (.sys_clk, .phase, .rd_active, .bus_addr,
      .ready_pol(pol), .wait_n, .ready_pin, .data_in);
   initial forever #10 sys_clk = ~sys_clk;
   initial begin
      #400000;
      errors++;
      complete_run();
   end
   task automatic complete_run;
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", n, exp, got);
      end
   endtask
   // One bus cycle; phase lengths counted at each falling edge
   task automatic cyc(input int cs, win, wr, input logic [5:0] wn);
      int k, cs_n = 0, cmd_n = 0, bad_n = 0;
      @(negedge sys_clk);
      req_cs = CS_IDX_W'(cs);
      req_window = 8'(win);
      req_write = wr[0];
      req_addr = req_addr + 24'h012345;
      req_wdata = req_addr[15:0] ^ 16'h0f0f;
      pol = tim[cs].ready_pol;
      wait_n = wn;
      req_valid = 1'b1;
      cnt = '{default: 0};
      oe_seen = 1'b0;
      @(negedge sys_clk);
      req_valid = 1'b0;
      for (k = 0; k < 300 && done !== 1'b1; k++) begin
         cnt[phase]++;
         oe_seen = oe_seen | data_oe;
         cs_n += cs_active;
         cmd_n += (wr != 0) ? wr_active : rd_active;
         bad_n += (wr != 0) ? rd_active : wr_active;
         @(negedge sys_clk);
      end
      chk("done", done, 1'b1);
      chk("cs", cs_n, cnt[1] + cnt[2] + cnt[3] + cnt[4] + cnt[5]);
      chk("cmd", cmd_n, cnt[4]);
      chk("cmd other", bad_n, 0);
      chk("addr", bus_addr, req_addr);
      if (wr != 0) begin
         chk("oe", oe_seen, 1'b1);
         chk("wdata", data_out, req_wdata);
      end else begin
         chk("rdata", rdata, req_addr[15:0] ^ 16'h5a5a);
      end
   endtask
   task automatic chk_ph(input int s, c, w, h);
      chk("setup", cnt[1], s);
      chk("cmd", cnt[2], c);
      chk("wsetup", cnt[3], w);
      chk("hold", cnt[5], h);
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      chk("rst phase", phase, EBCPS_IDLE);
      chk("rst ready", req_ready, 1'b1);
      chk("rst done", done, 1'b0);
      rst = 1'b0;
      foreach (rows[i]) begin
         cyc(rows[i].cs, rows[i].win, rows[i].wr, 6'h00);
         chk_ph(rows[i].s, rows[i].c, rows[i].w, rows[i].h);
         chk("access", cnt[4], rows[i].a);
      end
      // Slow ready stretches the access phase
      cyc(2, 2, 0, 6'h0a);
      chk_ph(1, 1, 0, 1);
      chk("slow", cnt[4] >= 11 && cnt[4] <= 13, 1'b1);
      // Asynchronous low ready costs at least one waitstate
      cyc(3, 2, 1, 6'h00);
      chk_ph(2, 2, 1, 2);
      chk("async", cnt[4] >= 2 && cnt[4] <= 5, 1'b1);
      // Reset in mid cycle, then window history restarts
      @(negedge sys_clk);
      req_cs = 2'h1;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      repeat (10) @(negedge sys_clk);
      rst = 1'b1;
      @(negedge sys_clk);
      chk("abort phase", phase, EBCPS_IDLE);
      chk("abort cs", cs_active, 1'b0);
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      cyc(1, 3, 0, 6'h00);
      chk_ph(5, 3, 1, 3);
      chk("access max", cnt[4], 32);
      #1;
      chk("ref clk", rco, 1'b0);
      @(posedge sys_clk);
      #1;
      chk("ref clk hi", rco, 1'b1);
      chk("clk sel", {ecs, cfe}, 2'h3);
      complete_run();
   end
endmodule
bind ebcps_seq ebcps_seq_assertions i_chk (.sys_clk, .rst,
   .chip_select_timing_control, .req_valid, .req_ready, .req_cs, .phase,
   .done, .external_clock_output_select, .clk_fast_driver_en);
